// File: verilog/sio_pkg.sv
// Package: constants and types for the safety interlock output block
package sio_pkg;

   // Register byte offsets
   localparam logic [7:0] ADDR_CONFIG     = 8'h00;
   localparam logic [7:0] ADDR_STATUS     = 8'h04;
   localparam logic [7:0] ADDR_IRQ_STATUS = 8'h08;
   localparam logic [7:0] ADDR_IRQ_MASK   = 8'h0C;
   localparam logic [7:0] ADDR_SPEC_INPUT = 8'h10;
   localparam logic [7:0] ADDR_EXPORT_LO  = 8'h14;
   localparam logic [7:0] ADDR_EXPORT_HI  = 8'h18;

   // Config field positions: which logic signals the user program drives
   localparam int CFG_USE_ENABLE = 0;
   localparam int CFG_USE_ESTOP  = 1;
   localparam int CFG_USE_FSPEED = 2;
   localparam int CFG_USE_FENCE  = 3;
   localparam int CFG_WIDTH      = 4;

   // Status field positions
   localparam int STS_PERMIT     = 0;
   localparam int STS_FULL_SPEED = 1;
   localparam int STS_CAUSE_LSB  = 4;

   // Event bit positions in the interrupt status and mask
   localparam int EV_WIRED_ESTOP = 0;
   localparam int EV_LOGIC_ESTOP = 1;
   localparam int EV_WIRED_FENCE = 2;
   localparam int EV_LOGIC_FENCE = 3;
   localparam int EV_LOGIC_ENSW  = 4;
   localparam int EV_PERMIT_LOST = 5;
   localparam int EV_WIDTH       = 6;

   // Reset values
   localparam logic [CFG_WIDTH-1:0] CONFIG_RESET = 4'h0;
   localparam logic [EV_WIDTH-1:0]  EVENT_RESET  = 6'h00;

   // Operating modes
   typedef enum logic [1:0] {
      SIO_MODE_TEACH  = 2'h0,
      SIO_MODE_PLAY   = 2'h1,
      SIO_MODE_REMOTE = 2'h2
   } sio_mode_type;

   // Pendant stop-cause codes
   typedef enum logic [3:0] {
      SIO_CAUSE_NONE        = 4'h0,
      SIO_CAUSE_FSPEED_LOG  = 4'h1,
      SIO_CAUSE_ESTOP_WIRED = 4'h2,
      SIO_CAUSE_ESTOP_LOG   = 4'h3,
      SIO_CAUSE_ENSW_LOG    = 4'h4,
      SIO_CAUSE_FENCE_WIRED = 4'h5,
      SIO_CAUSE_FENCE_LOG   = 4'h6
   } sio_cause_type;

   // Outputs of the user safety logic program
   typedef struct packed {
      logic [63:0] functional_safety_export;
      logic        logic_enable_switch;
      logic        logic_emergency_stop;
      logic        logic_full_speed_request;
      logic        logic_fence_closed;
   } sio_logic_type;

   // Hard-wired safety inputs
   typedef struct packed {
      logic wired_emergency_stop;
      logic wired_fence_closed;
      logic pendant_enable;
   } sio_wired_type;

endpackage

// File: verilog/sio_interlock.sv
// Safety interlock: servo permission, speed limit, stop cause, specific inputs
`timescale 1ns/1ps
// Register map, byte offsets on an 8-bit bus address
//   0x00 config     read/write, one use bit per logic signal
//        bit 0      logic enable switch is driven by the program
//        bit 1      logic emergency stop is driven by the program
//        bit 2      logic full speed request is driven by the program
//        bit 3      logic fence signal is driven by the program
//   0x04 status     read only
//        bit 0      servo power permitted
//        bit 1      full speed permitted
//        bits 7:4   stop cause code
//   0x08 irq status sticky events, write one to clear
//   0x0C irq mask   same layout as irq status
//   0x10 specific   read only copy of the specific inputs
//   0x14 export lo  read only, export bits 31:0
//   0x18 export hi  read only, export bits 63:32
//   Only bits 5:0 of irq status and irq mask exist
//   Other offsets read zero and ignore writes, but are still acknowledged
//
// Event bits
//   bit 0  wired emergency stop open
//   bit 1  effective logic emergency stop off
//   bit 2  wired fence open
//   bit 3  logic fence off in play mode
//   bit 4  logic enable switch off in teach mode
//   bit 5  servo permission lost, one cycle
//   A condition that still holds sets its bit again every cycle, so
//   software can only clear a cause once it has gone away.
//
// Stop cause codes, highest priority first
//   wired emergency stop, logic emergency stop, wired fence,
//   logic fence (play), logic enable switch (teach),
//   full speed test (teach), none.
//   Pendant enable released alone stops the servo in teach mode but has no code.
//   A stop cause clears by itself once its condition is gone.
//
// Timing
//   Every input is sampled on each rising edge; all results appear one
//   edge later. Permission is registered, so it drops one cycle after a
//   permissive goes off: this buys a clean flip-flop output at the cost
//   of one cycle of reaction time.
//   A bus access is taken on the edge with cyc and stb high and ack low;
//   ack and read data follow on the next edge and stand for one cycle.
//   Back to back accesses need no idle cycle; a request still held while ack is high is ignored.
//   An unmapped or read-only offset is written without effect and still
//   answered, so a wrong address never hangs the bus.
//   Specific inputs keep their order: input 1 in bit 0, eights upward.
//
// Reset
//   Reset is synchronous and active high. Configuration clears to zero,
//   so every logic signal counts as undriven and permissive except the
//   full speed request, which counts as off. Permission stays off until
//   the first edge after reset has sampled the inputs.
//   The mask clears to zero, so the interrupt stays low until enabled.
//
// Limitations
//   The mode input is taken as already debounced and synchronous.
//   Code 3 on the mode input behaves like remote mode.
//   Specific inputs and export data are passed through only; nothing in
//   the servo path reads them, since they carry no safety integrity.
//   Wired emergency stop and wired fence are watched in every mode; the pendant
//   enable, logic enable switch, logic fence and full speed request depend on the mode.
//   The interrupt is a level: it stays high while any unmasked status bit
//   is set, and falls on the same edge that takes the write clearing the last one.
//   Byte enables apply to writes only; reads always return a whole word.
//   Full speed is granted only in teach; in other modes the speed limit
//   is left to the reduced default of the controller.
module sio_interlock #(
   parameter int SPEC_WIDTH = 32
) (
   // Clock and reset
   input  wire logic                          clk_i,
   input  wire logic                          rst_i,
   // Wishbone classic slave
   input  wire logic                          wb_cyc_i,
   input  wire logic                          wb_stb_i,
   input  wire logic                          wb_we_i,
   input  wire logic [7:0]                    wb_adr_i,
   input  wire logic [3:0]                    wb_sel_i,
   input  wire logic [31:0]                   wb_dat_i,
   output logic      [31:0]                   wb_dat_o,
   output logic                               wb_ack_o,
   // Safety inputs
   input  wire sio_pkg::sio_mode_type         mode_i,
   input  wire sio_pkg::sio_wired_type        wired_i,
   input  wire sio_pkg::sio_logic_type        logic_i,
   input  wire logic [SPEC_WIDTH-1:0]         spec_input_i,
   // Interlock results
   output logic                               servo_permit_o,
   output logic                               full_speed_o,
   output sio_pkg::sio_cause_type             stop_cause_o,
   output logic [SPEC_WIDTH-1:0]              spec_input_o,
   output logic [63:0]                        functional_safety_export_o,
   output logic                               irq_o
);

   // Byte-lane merge used by every writable register
   function automatic logic [31:0] sio_merge(input logic [31:0] old_v,
                                             input logic [31:0] new_v,
                                             input logic [3:0]  sel);
      logic [31:0] m;
      m = {{8{sel[3]}}, {8{sel[2]}}, {8{sel[1]}}, {8{sel[0]}}};
      sio_merge = (old_v & ~m) | (new_v & m);
   endfunction

   // State
   logic [sio_pkg::CFG_WIDTH-1:0] config_r;
   logic [sio_pkg::EV_WIDTH-1:0]  irq_status;
   logic [sio_pkg::EV_WIDTH-1:0]  irq_mask;
   logic                          permit_q;
   logic [sio_pkg::CFG_WIDTH-1:0] next_config;
   logic [sio_pkg::EV_WIDTH-1:0]  next_irq_status;
   logic [sio_pkg::EV_WIDTH-1:0]  next_irq_mask;
   logic [31:0]                   next_dat;
   logic                          next_ack;
   logic                          next_permit;
   logic                          next_full_speed;
   sio_pkg::sio_cause_type        next_cause;
   logic [SPEC_WIDTH-1:0]         next_spec;
   logic [63:0]                   next_export;
   logic                          next_irq;

   // Effective permissives
   logic teach;
   logic play;
   logic eff_enable;
   logic eff_estop;
   logic eff_fspeed;
   logic eff_fence;
   logic teach_ok;
   logic play_ok;
   logic [sio_pkg::EV_WIDTH-1:0]  events;

   // Bus request decode
   logic        wb_req;
   logic        wb_wr;
   logic [31:0] cfg_word;
   logic [31:0] mask_word;
   logic [31:0] clr_word;
   logic [31:0] status_word;

   // Mode decode and defaulting of undriven logic signals
   always_comb begin
      teach      = (mode_i == sio_pkg::SIO_MODE_TEACH);
      play       = (mode_i == sio_pkg::SIO_MODE_PLAY);
      // Undriven enable switch behaves as a short
      eff_enable = ~config_r[sio_pkg::CFG_USE_ENABLE] | logic_i.logic_enable_switch;
      // Undriven emergency stop behaves as a short
      eff_estop  = ~config_r[sio_pkg::CFG_USE_ESTOP] | logic_i.logic_emergency_stop;
      // Undriven full speed request never grants full speed
      eff_fspeed = config_r[sio_pkg::CFG_USE_FSPEED] & logic_i.logic_full_speed_request;
      // Undriven fence signal behaves as closed
      eff_fence  = ~config_r[sio_pkg::CFG_USE_FENCE] | logic_i.logic_fence_closed;
   end

   // Servo permission and speed limit
   always_comb begin
      // Enable switch only weighs in teach mode
      teach_ok    = ~teach | (eff_enable & wired_i.pendant_enable);
      // Logic fence only weighs in play mode
      play_ok     = ~play | eff_fence;
      // Wired stop and fence are watched in every mode, the pendant enable in teach only
      next_permit = wired_i.wired_emergency_stop & eff_estop
                  & wired_i.wired_fence_closed & play_ok
                  & teach_ok;
      next_full_speed = teach & eff_fspeed;
   end

   // Stop cause, highest priority first: emergency stop, fence, enable, test
   always_comb begin
      if (!wired_i.wired_emergency_stop) begin
         next_cause = sio_pkg::SIO_CAUSE_ESTOP_WIRED;
      end else if (!eff_estop) begin
         next_cause = sio_pkg::SIO_CAUSE_ESTOP_LOG;
      end else if (!wired_i.wired_fence_closed) begin
         next_cause = sio_pkg::SIO_CAUSE_FENCE_WIRED;
      end else if (play && !eff_fence) begin
         next_cause = sio_pkg::SIO_CAUSE_FENCE_LOG;
      end else if (teach && !eff_enable) begin
         next_cause = sio_pkg::SIO_CAUSE_ENSW_LOG;
      end else if (teach && eff_fspeed) begin
         next_cause = sio_pkg::SIO_CAUSE_FSPEED_LOG;
      end else begin
         next_cause = sio_pkg::SIO_CAUSE_NONE;
      end
   end

   // Pass-through data: export set and specific inputs
   always_comb begin
      next_export = logic_i.functional_safety_export;
      // Input 1 sits in bit 0, groups of eight follow upward
      next_spec   = spec_input_i;
   end

   // Event detection; pendant enable release alone only sets the permission lost bit
   always_comb begin
      events = '0;
      events[sio_pkg::EV_WIRED_ESTOP] = ~wired_i.wired_emergency_stop;
      events[sio_pkg::EV_LOGIC_ESTOP] = ~eff_estop;
      events[sio_pkg::EV_WIRED_FENCE] = ~wired_i.wired_fence_closed;
      events[sio_pkg::EV_LOGIC_FENCE] = play & ~eff_fence;
      events[sio_pkg::EV_LOGIC_ENSW]  = teach & ~eff_enable;
      events[sio_pkg::EV_PERMIT_LOST] = permit_q & ~next_permit;
   end

   // Address decode shared by every register write
   function automatic logic sio_hit(input logic [7:0] adr,
                                    input logic [7:0] offset);
      sio_hit = (adr == offset);
   endfunction

   // Bus request: the ack cycle itself is never taken as a new access
   always_comb begin
      wb_req      = wb_cyc_i & wb_stb_i & ~wb_ack_o;
      wb_wr       = wb_req & wb_we_i;
      // Only the written byte lanes change; a partial write keeps the rest
      cfg_word    = sio_merge({28'h0000000, config_r}, wb_dat_i, wb_sel_i);
      mask_word   = sio_merge({26'h0000000, irq_mask}, wb_dat_i, wb_sel_i);
      clr_word    = sio_merge(32'h00000000, wb_dat_i, wb_sel_i);
      // Status shows the registered outputs, so a read matches the pins
      status_word = {24'h000000, stop_cause_o, 2'h0, full_speed_o, servo_permit_o};
   end

   // Configuration: which logic signals the user program really drives
   always_comb begin
      next_config = config_r;
      if (wb_wr && sio_hit(wb_adr_i, sio_pkg::ADDR_CONFIG)) begin
         next_config = cfg_word[sio_pkg::CFG_WIDTH-1:0];
      end
   end

   // Interrupt mask, same layout as the sticky status
   always_comb begin
      next_irq_mask = irq_mask;
      if (wb_wr && sio_hit(wb_adr_i, sio_pkg::ADDR_IRQ_MASK)) begin
         next_irq_mask = mask_word[sio_pkg::EV_WIDTH-1:0];
      end
   end

   // Sticky event status, cleared by writing ones
   always_comb begin
      next_irq_status = irq_status;
      if (wb_wr && sio_hit(wb_adr_i, sio_pkg::ADDR_IRQ_STATUS)) begin
         next_irq_status = irq_status & ~clr_word[sio_pkg::EV_WIDTH-1:0];
      end
      // A new event wins over a clear in the same cycle, so a held fault stays visible
      next_irq_status = next_irq_status | events;
      // The interrupt follows status and mask on the same edge
      next_irq        = |(next_irq_status & next_irq_mask);
   end

   // Read mux and answer; data is zero outside the ack cycle
   always_comb begin
      next_ack = wb_req;
      next_dat = 32'h00000000;
      if (wb_req && !wb_we_i) begin
         case (wb_adr_i)
            sio_pkg::ADDR_CONFIG:     next_dat = {28'h0000000, config_r};
            sio_pkg::ADDR_STATUS:     next_dat = status_word;
            sio_pkg::ADDR_IRQ_STATUS: next_dat = {26'h0000000, irq_status};
            sio_pkg::ADDR_IRQ_MASK:   next_dat = {26'h0000000, irq_mask};
            // Non-safety data: software sees it, servo logic never uses it
            sio_pkg::ADDR_SPEC_INPUT: next_dat = 32'(spec_input_o);
            sio_pkg::ADDR_EXPORT_LO:  next_dat = functional_safety_export_o[31:0];
            sio_pkg::ADDR_EXPORT_HI:  next_dat = functional_safety_export_o[63:32];
            default:                  next_dat = 32'h00000000;
         endcase
      end
   end

   // Software registers and interrupt line
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         config_r   <= sio_pkg::CONFIG_RESET;
         irq_status <= sio_pkg::EVENT_RESET;
         irq_mask   <= sio_pkg::EVENT_RESET;
         irq_o      <= 1'b0;
      end else begin
         config_r   <= next_config;
         irq_status <= next_irq_status;
         irq_mask   <= next_irq_mask;
         irq_o      <= next_irq;
      end
   end

   // Interlock results; permission resets low so power stays off until inputs settle
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         permit_q       <= 1'b0;
         servo_permit_o <= 1'b0;
         full_speed_o   <= 1'b0;
         stop_cause_o   <= sio_pkg::SIO_CAUSE_NONE;
      end else begin
         permit_q       <= next_permit;
         servo_permit_o <= next_permit;
         full_speed_o   <= next_full_speed;
         stop_cause_o   <= next_cause;
      end
   end

   // Pass-through data, one cycle behind the inputs
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         spec_input_o               <= '0;
         functional_safety_export_o <= 64'h0000000000000000;
      end else begin
         spec_input_o               <= next_spec;
         functional_safety_export_o <= next_export;
      end
   end

   // Bus answer: ack and read data stand for exactly one cycle
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         wb_ack_o <= 1'b0;
         wb_dat_o <= 32'h00000000;
      end else begin
         wb_ack_o <= next_ack;
         wb_dat_o <= next_dat;
      end
   end

endmodule

// File: tb/sio_interlock_props.sv
// Checker: port relations of the safety interlock
`timescale 1ns/1ps
module sio_interlock_props #(
   parameter int SPEC_WIDTH = 32
) (
   // Clock, reset and bus handshake
   input wire logic                   clk_i,
   input wire logic                   rst_i,
   input wire logic                   wb_cyc_i,
   input wire logic                   wb_stb_i,
   input wire logic                   wb_ack_o,
   // Interlock inputs and results
   input wire sio_pkg::sio_mode_type  mode_i,
   input wire sio_pkg::sio_wired_type wired_i,
   input wire sio_pkg::sio_logic_type logic_i,
   input wire logic [SPEC_WIDTH-1:0]  spec_input_i,
   input wire logic                   servo_permit_o,
   input wire logic                   full_speed_o,
   input wire sio_pkg::sio_cause_type stop_cause_o,
   input wire logic [SPEC_WIDTH-1:0]  spec_input_o,
   input wire logic [63:0]            functional_safety_export_o
);
   default clocking @(posedge clk_i); endclocking
   default disable iff (rst_i);
   a_wired_estop_cause: assert property (!wired_i.wired_emergency_stop |=> !servo_permit_o
      && stop_cause_o == sio_pkg::SIO_CAUSE_ESTOP_WIRED) else $error("wired stop not obeyed");
   a_fence_drops_permit: assert property (!wired_i.wired_fence_closed |=> !servo_permit_o)
      else $error("fence open kept permit");
   a_pendant_teach: assert property (mode_i == sio_pkg::SIO_MODE_TEACH
      && !wired_i.pendant_enable |=> !servo_permit_o) else $error("pendant off kept permit");
   a_fspeed_teach_only: assert property (mode_i != sio_pkg::SIO_MODE_TEACH |=> !full_speed_o)
      else $error("full speed outside teach");
   a_spec_copy: assert property (1'b1 |=> spec_input_o == $past(spec_input_i))
      else $error("specific inputs not mapped");
   a_export_copy: assert property (1'b1 |=> functional_safety_export_o == $past(logic_i[67:4]))
      else $error("export data not forwarded");
   a_quiet_cause: assert property (servo_permit_o && !full_speed_o
      |-> stop_cause_o == sio_pkg::SIO_CAUSE_NONE) else $error("cause shown while permitted");
   a_permit_and: assert property (servo_permit_o
      |-> $past(wired_i.wired_emergency_stop && wired_i.wired_fence_closed))
      else $error("permit without wired permissives");
   a_ack_pulse: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o ##1 !wb_ack_o)
      else $error("ack not a one cycle answer");
endmodule

// File: tb/sio_safety_env.sv
// Far side model: safety devices, operating mode and user logic program
`timescale 1ns/1ps
module sio_safety_env (
   // Clock
   input  wire logic              clk_i,
   // Levels presented to the interlock
   output sio_pkg::sio_mode_type  mode_o,
   output sio_pkg::sio_wired_type wired_o,
   output sio_pkg::sio_logic_type logic_o,
   output logic [31:0]            spec_o
);
   // Power-up: all devices closed, teach mode, fixed export word
   initial begin
      mode_o = sio_pkg::SIO_MODE_TEACH;
      wired_o = 3'h7;
      logic_o = {64'h0123_4567_89AB_CDEF, 4'hF};
      spec_o = 32'h8000_0001; // Input 1 sits at bit 0
   end
   // Levels change just after an edge; spec_o never feeds a safety bit here
   task automatic set(input logic [1:0] m, input logic [2:0] w, input logic [3:0] l);
      @(posedge clk_i);
      mode_o <= sio_pkg::sio_mode_type'(m);
      wired_o <= w;
      logic_o[3:0] <= l;
   endtask
endmodule

// File: tb/test_sio_interlock.sv
// Testbench: interlock decisions, stop causes, registers and interrupt
`timescale 1ns/1ps
module test_sio_interlock;
   logic                   clk_i = 1'b0;
   logic                   rst_i = 1'b1;
   logic                   wb_cyc_i = 1'b0;
   logic                   wb_stb_i = 1'b0;
   logic                   wb_we_i = 1'b0;
   logic [7:0]             wb_adr_i = 8'h00;
   logic [3:0]             wb_sel_i = 4'hF;
   logic [31:0]            wb_dat_i = 32'h0;
   logic [31:0]            wb_dat_o, spec_i, spec_input_o;
   logic                   wb_ack_o, servo_permit_o, full_speed_o, irq_o;
   logic [63:0]            export_o;
   sio_pkg::sio_mode_type  mode;
   sio_pkg::sio_wired_type wired;
   sio_pkg::sio_logic_type lgc;
   sio_pkg::sio_cause_type stop_cause_o;
   int                     errors = 0;
   int                     check_count = 0;
   sio_interlock i_dut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
      .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
      .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .mode_i(mode), .wired_i(wired), .logic_i(lgc),
      .spec_input_i(spec_i), .servo_permit_o(servo_permit_o), .full_speed_o(full_speed_o),
      .stop_cause_o(stop_cause_o), .spec_input_o(spec_input_o),
      .functional_safety_export_o(export_o), .irq_o(irq_o));
   sio_safety_env env (.clk_i(clk_i), .mode_o(mode), .wired_o(wired), .logic_o(lgc),
      .spec_o(spec_i));
   // Clock at 50 MHz
   initial begin
      forever #10 clk_i = ~clk_i;
   end
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      check_count++;
      if (seen !== exp) begin
         errors++;
         $display("Error at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask
   // Classic cycle: hold until ack is seen high at a rising edge
   task automatic wb(input logic we, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] q);
      int n;
      @(posedge clk_i);
      wb_cyc_i <= 1'b1;
      wb_stb_i <= 1'b1;
      wb_we_i <= we;
      wb_adr_i <= a;
      wb_dat_i <= d;
      n = 0;
      do begin
         @(posedge clk_i);
         n++;
      end while (wb_ack_o !== 1'b1 && n < 20);
      // Data is taken and the request released at the edge that sees ack high
      q = wb_dat_o;
      check(32'(wb_ack_o), 32'h1);
      wb_cyc_i <= 1'b0;
      wb_stb_i <= 1'b0;
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic [31:0] q;
      wb(1'b1, a, d, q);
   endtask
   task automatic rd(input logic [7:0] a, input logic [31:0] e);
      logic [31:0] q;
      wb(1'b0, a, 32'h0, q);
      check(q, e);
   endtask
   task automatic settle;
      repeat (2) @(posedge clk_i);
      @(negedge clk_i);
   endtask
   // Logic bits are {enable, estop, full speed, fence}; s is {cause, 00, speed, permit}
   task automatic apply(input logic [3:0] c, input logic [1:0] m, input logic [2:0] w,
                        input logic [3:0] l, input logic [7:0] s);
      wr(sio_pkg::ADDR_CONFIG, {28'h0, c});
      env.set(m, w, l);
      settle;
      check({24'h0, 4'(stop_cause_o), 2'h0, full_speed_o, servo_permit_o}, {24'h0, s});
      rd(sio_pkg::ADDR_STATUS, {24'h0, s});
   endtask
   task automatic close_out;
      $display("Comparisons %0d, mismatches %0d", check_count, errors);
      if (errors == 0 && check_count > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask
   // Watchdog well beyond the expected run
   initial begin
      repeat (5000) @(posedge clk_i);
      errors++;
      close_out;
   end
   // Main sequence
   initial begin
      repeat (6) @(posedge clk_i);
      rst_i <= 1'b0;
      rd(sio_pkg::ADDR_CONFIG, 32'h0);
      rd(sio_pkg::ADDR_IRQ_MASK, 32'h0);
      rd(sio_pkg::ADDR_SPEC_INPUT, 32'h8000_0001);
      rd(sio_pkg::ADDR_EXPORT_LO, 32'h89AB_CDEF);
      rd(sio_pkg::ADDR_EXPORT_HI, 32'h0123_4567);
      wr(sio_pkg::ADDR_STATUS, 32'hFF);
      rd(sio_pkg::ADDR_STATUS, 32'h01);
      rd(8'h1C, 32'h0);
      $display("Test registers done");
      apply(4'h0, 2'h0, 3'h7, 4'h0, 8'h01);
      apply(4'hF, 2'h0, 3'h7, 4'h4, 8'h40);
      apply(4'hF, 2'h0, 3'h6, 4'hC, 8'h00);
      apply(4'hF, 2'h0, 3'h7, 4'hE, 8'h13);
      apply(4'hF, 2'h1, 3'h7, 4'h7, 8'h01);
      apply(4'hF, 2'h1, 3'h7, 4'hC, 8'h60);
      apply(4'hF, 2'h1, 3'h5, 4'hD, 8'h50);
      apply(4'hF, 2'h2, 3'h7, 4'hA, 8'h30);
      apply(4'hF, 2'h2, 3'h3, 4'hA, 8'h20);
      apply(4'h0, 2'h1, 3'h7, 4'h0, 8'h01);
      apply(4'hF, 2'h2, 3'h7, 4'h6, 8'h01);
      $display("Test interlock done");
      apply(4'hF, 2'h0, 3'h7, 4'hD, 8'h01);
      wr(sio_pkg::ADDR_IRQ_MASK, 32'h21);
      wr(sio_pkg::ADDR_IRQ_STATUS, 32'h3F);
      settle;
      check(32'(irq_o), 32'h0);
      env.set(2'h0, 3'h3, 4'hD);
      settle;
      check(32'(irq_o), 32'h1);
      rd(sio_pkg::ADDR_IRQ_STATUS, 32'h21);
      wr(sio_pkg::ADDR_IRQ_STATUS, 32'h21);
      rd(sio_pkg::ADDR_IRQ_STATUS, 32'h01);
      wr(sio_pkg::ADDR_IRQ_MASK, 32'h20);
      settle;
      check(32'(irq_o), 32'h0);
      $display("Test interrupt done");
      close_out;
   end
endmodule
bind sio_interlock sio_interlock_props #(.SPEC_WIDTH(SPEC_WIDTH)) i_props (.clk_i(clk_i),
   .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_ack_o(wb_ack_o),
   .mode_i(mode_i), .wired_i(wired_i), .logic_i(logic_i), .spec_input_i(spec_input_i),
   .servo_permit_o(servo_permit_o), .full_speed_o(full_speed_o), .stop_cause_o(stop_cause_o),
   .spec_input_o(spec_input_o), .functional_safety_export_o(functional_safety_export_o));
